//--- fplk_flash_model.sv
// Flash sink model: keeps the last item per index
`default_nettype none
module fplk_flash_model (
    input wire logic        clk_i,
    input wire logic        nv_wr_i,
    input wire logic [5:0]  nv_idx_i,
    input wire logic [83:0] nv_data_i,
    output var int          wr_cnt_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [fplk_pkg::ENT_W-1:0] mem [64];
    initial wr_cnt_o = 0;
    // no back-pressure, so every pulse lands
    always @(posedge clk_i) begin
        if (nv_wr_i === 1'b1) begin
            mem[nv_idx_i] <= nv_data_i;
            wr_cnt_o <= wr_cnt_o + 1;
        end
    end
endmodule // fplk_flash_model
`default_nettype wire

//--- fplk_keeper.sv
// Fault log, peak log, reset count and run-time clock keeper
//
// Behaviour
// R1 - The fault log keeps at most 18 entries and a device reset count is kept in flash.
// R2 - Each rail has a peak; a rise above the logged peak opens a 30 s window after which the peak is written.
// R3 - With logging disabled records stay in SRAM only and no flash writes happen.
// R4 - A fault entry holds rail, fault type, time stamp and the rail's last measured voltage.
// R5 - The reset count lives in flash and the host may clear it to zero.
// R6 - Non-circular policy keeps the first 18 faults and ignores later ones until cleared.
// R7 - Full circular policy keeps the 18 newest faults, dropping the oldest.
// R8 - Half circular policy keeps the first 9 faults and runs the other 9 as a ring.
// R9 - In brownout mode clock, peaks and faults reach flash only when power-down is seen.
// R10 - In brownout mode the run-time clock survives resets, otherwise it restarts at zero.
// R11 - The host may write the run-time clock and converts its units itself.
// R12 - A supply below 2.9 V, as flagged by the comparator, is a brownout event.
// R13 - A brownout event copies all SRAM log data to flash unless logging is disabled.
// R14 - Brownout mode is off unless the host enables it in configuration.
// R15 - The run-time clock is a 32-bit millisecond count and a 32-bit day count.
// R16 - Each logged fault is stamped with the current run-time clock.
// R17 - Clearing the fault log empties it and restarts the overflow policy.
`default_nettype none
module fplk_keeper #(
    parameter int MS_CYCLES   = fplk_pkg::MS_CYC,
    parameter int PEAK_CYCLES = fplk_pkg::PEAK_CYC
) (
    // Clock, reset, enable
    input  wire logic                          clk_i,
    input  wire logic                          nrst_i,
    input  wire logic                          ce_i,
    // Values restored from flash at start-up
    input  wire logic [31:0]                   rst_cnt_nv_i,
    input  wire logic [31:0]                   rtc_ms_nv_i,
    input  wire logic [31:0]                   rtc_day_nv_i,
    input  wire logic                          bo_mode_nv_i,
    // Rail measurements
    input  wire logic                          meas_vld_i,
    input  wire logic [fplk_pkg::RAIL_W-1:0]   meas_rail_i,
    input  wire logic [fplk_pkg::VOLT_W-1:0]   meas_volt_i,
    // Fault events
    input  wire logic                          flt_vld_i,
    input  wire logic [fplk_pkg::RAIL_W-1:0]   flt_rail_i,
    input  wire logic [fplk_pkg::TYPE_W-1:0]   flt_type_i,
    // Supply comparator, asynchronous
    input  wire logic                          supply_low_i,
    // Register port
    input  wire logic [7:0]                    addr_i,
    input  wire logic [31:0]                   wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic      [31:0]                   rdata_o,
    // Flash write port
    output logic                               nv_wr_o,
    output logic      [fplk_pkg::NV_W-1:0]     nv_idx_o,
    output logic      [fplk_pkg::ENT_W-1:0]    nv_data_o,
    // Interrupt
    output logic                               irq_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Reset release, two stages
    logic [1:0]            rst_q;
    logic                  rst_n;
    fplk_pkg::fplk_state_s st;
    fplk_pkg::fplk_state_s nx;

    // Release is synchronous so no flop sees a half-released reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [fplk_pkg::PC_W-1:0]   pset;
        logic [fplk_pkg::PC_W-1:0]   allow;
        logic [fplk_pkg::EV_W-1:0]   ev;
        logic [fplk_pkg::EV_W-1:0]   clr;
        logic                        bo_rise;
        logic [fplk_pkg::NV_W-1:0]   off;
        logic [fplk_pkg::RAIL_W-1:0] r;
        logic [fplk_pkg::CNT_W-1:0]  fi;
        int                          cls;
        fplk_pkg::fplk_ent_s         e;
        nx      = st;
        pset    = '0;
        allow   = '0;
        ev      = '0;
        clr     = '0;
        off     = '0;
        r       = '0;
        fi      = '0;
        cls     = fplk_pkg::PC_CNT;
        e       = '0;
        nx.rd_data = 32'h0;
        nx.nv_wr   = 1'b0;

        // R12 - comparator trip detection; a change counts once stages 2 and 3 agree
        nx.bo_sync = {st.bo_sync[1:0], supply_low_i};
        bo_rise    = (st.bo_sync[1] == st.bo_sync[2]) && st.bo_sync[2] && !st.bo_lvl;
        if (st.bo_sync[1] == st.bo_sync[2]) begin
            nx.bo_lvl = st.bo_sync[2];
        end
        if (bo_rise) begin
            ev[fplk_pkg::EV_BO] = 1'b1;
            // R13 - brownout flushes every class
            pset     = '1;
            nx.flush = 1'b1;
        end

        // R15 - millisecond and day counters
        if (st.mscnt == 32'(MS_CYCLES - 1)) begin
            nx.mscnt = 32'h0;
            if (st.ms == fplk_pkg::MS_PER_DAY - 32'h1) begin
                nx.ms  = 32'h0;
                nx.day = st.day + 32'h1;
            end else begin
                nx.ms = st.ms + 32'h1;
            end
        end else begin
            nx.mscnt = st.mscnt + 32'h1;
        end

        // R2 - peak tracking and the shared write-back window
        if (meas_vld_i) begin
            nx.last[meas_rail_i] = meas_volt_i;
            if (meas_volt_i > st.pk[meas_rail_i]) begin
                nx.pk[meas_rail_i] = meas_volt_i;
            end
            if (meas_volt_i > st.nvpk[meas_rail_i] && !st.win_on) begin
                nx.win_on = 1'b1;
                nx.wincnt = 32'h0;
            end
        end
        if (st.win_on) begin
            if (st.wincnt == 32'(PEAK_CYCLES - 1)) begin
                nx.win_on = 1'b0;
                pset[fplk_pkg::PC_PK] = 1'b1;
                ev[fplk_pkg::EV_PEAK] = 1'b1;
            end else begin
                nx.wincnt = st.wincnt + 32'h1;
            end
        end

        // R4 - build the entry; R16 - stamp with the clock
        e.rail  = flt_rail_i;
        e.ftype = flt_type_i;
        e.volt  = st.last[flt_rail_i];
        e.ms    = st.ms;
        e.day   = st.day;
        if (flt_vld_i) begin
            if (st.fcnt < fplk_pkg::FCNT_FULL) begin
                // R1 - append while room remains
                nx.log[st.fcnt] = e;
                nx.fcnt = st.fcnt + 5'h1;
                ev[fplk_pkg::EV_LOG]   = 1'b1;
                pset[fplk_pkg::PC_FLT] = 1'b1;
            end else if (st.pol == fplk_pkg::FPLK_POL_FULL ||
                         st.pol == fplk_pkg::FPLK_POL_HALF) begin
                // R7 - full ring; R8 - only the upper half moves
                for (int i = 0; i < fplk_pkg::LOG_DEPTH - 1; i++) begin
                    if (st.pol == fplk_pkg::FPLK_POL_FULL || i >= fplk_pkg::LOG_HALF) begin
                        nx.log[i] = st.log[i+1];
                    end
                end
                nx.log[fplk_pkg::LOG_DEPTH-1] = e;
                ev[fplk_pkg::EV_LOG]   = 1'b1;
                pset[fplk_pkg::PC_FLT] = 1'b1;
            end else begin
                // R6 - full and not circular: ignore
                ev[fplk_pkg::EV_DROP] = 1'b1;
            end
        end

        // Register writes
        if (wr_i) begin
            case (addr_i)
                fplk_pkg::REG_CTRL: begin
                    nx.logdis = wdata_i[fplk_pkg::CTRL_LOGDIS];
                    nx.pol    = fplk_pkg::fplk_pol_e'(wdata_i[fplk_pkg::CTRL_POL +: 2]);
                    // R14 - brownout mode only by configuration
                    nx.bo_en  = wdata_i[fplk_pkg::CTRL_BO];
                end
                fplk_pkg::REG_CMD: begin
                    if (wdata_i[fplk_pkg::CMD_CLRLOG]) begin
                        // R17 - empty log, policy starts over
                        nx.fcnt = '0;
                        nx.log  = '0;
                        pset[fplk_pkg::PC_FLT] = 1'b1;
                    end
                    if (wdata_i[fplk_pkg::CMD_CLRCNT]) begin
                        // R5 - host clears the reset count
                        nx.cnt = 32'h0;
                        pset[fplk_pkg::PC_CNT] = 1'b1;
                    end
                end
                // R11 - host sets the clock
                fplk_pkg::REG_MS: begin
                    nx.ms    = wdata_i;
                    nx.mscnt = 32'h0;
                end
                fplk_pkg::REG_DAY:  nx.day = wdata_i;
                fplk_pkg::REG_SEL:  nx.sel = wdata_i[7:0];
                fplk_pkg::REG_ICLR: clr    = wdata_i[fplk_pkg::EV_W-1:0];
                fplk_pkg::REG_IEN:  nx.ien = wdata_i[fplk_pkg::EV_W-1:0];
                default: ;
            endcase
        end

        // Register reads, answered the following cycle
        if (rd_i) begin
            fi = st.sel[fplk_pkg::CNT_W-1:0];
            r  = st.sel[fplk_pkg::RAIL_W-1:0];
            case (addr_i)
                fplk_pkg::REG_CTRL: begin
                    nx.rd_data[fplk_pkg::CTRL_LOGDIS]     = st.logdis;
                    nx.rd_data[fplk_pkg::CTRL_POL +: 2]   = st.pol;
                    nx.rd_data[fplk_pkg::CTRL_BO]         = st.bo_en;
                end
                fplk_pkg::REG_STAT: begin
                    nx.rd_data[fplk_pkg::CNT_W-1:0] = st.fcnt;
                    nx.rd_data[fplk_pkg::ST_BUSY]   = (st.cm == fplk_pkg::FPLK_CM_WALK);
                    nx.rd_data[fplk_pkg::ST_BO]     = st.bo_lvl;
                    nx.rd_data[fplk_pkg::ST_FULL]   = (st.fcnt == fplk_pkg::FCNT_FULL);
                end
                fplk_pkg::REG_RCNT: nx.rd_data = st.cnt;
                fplk_pkg::REG_MS:   nx.rd_data = st.ms;
                fplk_pkg::REG_DAY:  nx.rd_data = st.day;
                fplk_pkg::REG_SEL:  nx.rd_data[7:0] = st.sel;
                fplk_pkg::REG_LINF: begin
                    if (st.sel < 8'(fplk_pkg::LOG_DEPTH)) begin
                        nx.rd_data[fplk_pkg::VOLT_W-1:0] = st.log[fi].volt;
                        nx.rd_data[19:16] = st.log[fi].ftype;
                        nx.rd_data[27:24] = st.log[fi].rail;
                    end
                end
                fplk_pkg::REG_LMS: begin
                    if (st.sel < 8'(fplk_pkg::LOG_DEPTH)) nx.rd_data = st.log[fi].ms;
                end
                fplk_pkg::REG_LDAY: begin
                    if (st.sel < 8'(fplk_pkg::LOG_DEPTH)) nx.rd_data = st.log[fi].day;
                end
                fplk_pkg::REG_PEAK: begin
                    if (st.sel < 8'(fplk_pkg::RAILS)) begin
                        nx.rd_data[fplk_pkg::VOLT_W-1:0] = st.pk[r];
                        nx.rd_data[27:16]                = st.last[r];
                    end
                end
                fplk_pkg::REG_IST: nx.rd_data[fplk_pkg::EV_W-1:0] = st.ists;
                fplk_pkg::REG_IEN: nx.rd_data[fplk_pkg::EV_W-1:0] = st.ien;
                default: ;
            endcase
        end

        // Flash commit walker; only the count commits at once in brownout mode
        // R9 - deferral of clock, peaks and faults
        if (st.logdis) begin
            allow = '0;
        end else if (st.bo_en && !st.flush) begin
            allow = 4'h1;
        end else begin
            allow = '1;
        end
        case (st.cm)
            fplk_pkg::FPLK_CM_IDLE: begin
                if ((st.pend & allow) != '0) begin
                    nx.act   = st.pend & allow;
                    nx.pend  = st.pend & ~allow;
                    nx.widx  = '0;
                    nx.flush = bo_rise;
                    nx.cm    = fplk_pkg::FPLK_CM_WALK;
                end
            end
            fplk_pkg::FPLK_CM_WALK: begin
                if (st.widx == fplk_pkg::NV_CNT) begin
                    nx.nv_data = fplk_pkg::ENT_W'(st.cnt);
                end else if (st.widx == fplk_pkg::NV_MS) begin
                    cls = fplk_pkg::PC_CLK;
                    nx.nv_data = fplk_pkg::ENT_W'(st.ms);
                end else if (st.widx == fplk_pkg::NV_DAY) begin
                    cls = fplk_pkg::PC_CLK;
                    nx.nv_data = fplk_pkg::ENT_W'(st.day);
                end else if (st.widx < fplk_pkg::NV_FAULT) begin
                    cls = fplk_pkg::PC_PK;
                    off = st.widx - fplk_pkg::NV_PEAK;
                    r   = off[fplk_pkg::RAIL_W-1:0];
                    nx.nv_data = fplk_pkg::ENT_W'(st.pk[r]);
                    if (st.act[fplk_pkg::PC_PK]) nx.nvpk[r] = st.pk[r];
                end else if (st.widx < fplk_pkg::NV_NUM) begin
                    cls = fplk_pkg::PC_FLT;
                    off = st.widx - fplk_pkg::NV_FAULT;
                    nx.nv_data = st.log[off[fplk_pkg::CNT_W-1:0]];
                end else begin
                    cls = fplk_pkg::PC_FLT;
                    nx.nv_data = fplk_pkg::ENT_W'(st.fcnt);
                end
                // R3 - writes only for classes let through above
                nx.nv_wr  = st.act[cls] & ~st.logdis;
                nx.nv_idx = st.widx;
                if (st.widx == fplk_pkg::NV_LAST) begin
                    nx.cm = fplk_pkg::FPLK_CM_IDLE;
                end else begin
                    nx.widx = st.widx + 6'h1;
                end
            end
            default: nx.cm = fplk_pkg::FPLK_CM_IDLE;
        endcase
        // New work survives a walker take-over in the same cycle
        nx.pend = st.logdis ? '0 : (nx.pend | pset);

        // Events are sticky; a new event beats a clear
        nx.ists = (st.ists & ~clr) | ev;
        nx.irq  = |(nx.ists & nx.ien);

        // First cycle after reset: restore from flash
        if (!st.init) begin
            nx.init  = 1'b1;
            nx.bo_en = bo_mode_nv_i;
            // R1 - count this reset and commit it
            nx.cnt   = rst_cnt_nv_i + 32'h1;
            nx.pend[fplk_pkg::PC_CNT] = 1'b1;
            // R10 - clock persists only in brownout mode
            if (bo_mode_nv_i) begin
                nx.ms  = rtc_ms_nv_i;
                nx.day = rtc_day_nv_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; clock enable freezes everything
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else if (ce_i) begin
            st <= nx;
        end
    end

    // Outputs straight from state flops
    assign rdata_o   = st.rd_data;
    assign nv_wr_o   = st.nv_wr;
    assign nv_idx_o  = st.nv_idx;
    assign nv_data_o = st.nv_data;
    assign irq_o     = st.irq;
endmodule // fplk_keeper
`default_nettype wire

//--- fplk_keeper_asserts.sv
// Port-level assertions for the log keeper
`default_nettype none
module fplk_keeper_asserts (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        nv_wr_o,
    input wire logic [5:0]  nv_idx_o,
    input wire logic [83:0] nv_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // Read data only answers a read
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data without read");
    nv_range_a: assert property (nv_wr_o |-> nv_idx_o <= 6'h25)
        else $error("flash index out of map");
    // Walk runs strictly upward
    nv_order_a: assert property (nv_wr_o && $past(nv_wr_o) |-> nv_idx_o > $past(nv_idx_o))
        else $error("flash items out of order");
    nv_zext_a: assert property (nv_wr_o && nv_idx_o < 6'h13 |-> nv_data_o[83:32] == '0)
        else $error("flash item not zero extended");
    // Disable lands after one walker stage
    logdis_quiet_a: assert property (wr_i && addr_i == 8'h00 && wdata_i[0]
        |=> ##1 !nv_wr_o [*8])
        else $error("flash write while disabled");
    entry_layout_a: assert property (rd_i && addr_i == 8'h1C
        |=> rdata_o[31:28] == 4'h0 && rdata_o[23:20] == 4'h0 && rdata_o[15:12] == 4'h0)
        else $error("entry stray bits");
    count_bound_a: assert property (rd_i && addr_i == 8'h04 |=> rdata_o[4:0] <= 5'h12)
        else $error("count above depth");
    wo_read_a: assert property (rd_i && addr_i inside {8'h08, 8'h30, [8'h35:8'hFF]}
        |=> rdata_o == 32'h0)
        else $error("write-only read not zero");
endmodule // fplk_keeper_asserts
bind fplk_keeper fplk_keeper_asserts u_chk (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .nv_wr_o, .nv_idx_o, .nv_data_o);
`default_nettype wire

//--- fplk_pkg.sv
// Shared constants and types of the fault and peak log keeper
`default_nettype none
package fplk_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // Log geometry and record widths
    localparam int          LOG_DEPTH = 32'h12;      // Fault entries kept
    localparam int          LOG_HALF  = 32'h9;       // Entries fixed in half mode
    localparam int          RAILS     = 32'h10;
    localparam int          RAIL_W    = 32'h4;
    localparam int          TYPE_W    = 32'h4;
    localparam int          VOLT_W    = 32'hC;
    localparam int          CNT_W     = 32'h5;
    localparam int          W32       = 32'h20;
    localparam logic [4:0]  FCNT_FULL = 5'h12;

    ////////////////////////////////////////////////////////////////////////////
    // Timing: times in their own units, cycles derived from the clock
    localparam int          CLK_HZ     = 32'h0098_9680; // 10 MHz
    localparam int          CLK_NS     = 32'h64;        // 100 ns period
    localparam int          MS_NS      = 32'h000F_4240; // One millisecond
    localparam int          PEAK_WIN_S = 32'h1E;        // Peak window, seconds
    localparam int          MS_CYC     = MS_NS / CLK_NS;
    localparam int          PEAK_CYC   = PEAK_WIN_S * CLK_HZ;
    localparam logic [31:0] MS_PER_DAY = 32'h0526_5C00;

    ////////////////////////////////////////////////////////////////////////////
    // Nonvolatile item map, one item per write
    localparam int          NV_W     = 32'h6;
    localparam logic [5:0]  NV_CNT   = 6'h00;
    localparam logic [5:0]  NV_MS    = 6'h01;
    localparam logic [5:0]  NV_DAY   = 6'h02;
    localparam logic [5:0]  NV_PEAK  = 6'h03;
    localparam logic [5:0]  NV_FAULT = 6'h13;        // After 16 peaks
    localparam logic [5:0]  NV_NUM   = 6'h25;        // After 18 faults
    localparam logic [5:0]  NV_LAST  = 6'h25;

    // Pending commit classes
    localparam int          PC_CNT = 0;
    localparam int          PC_CLK = 1;
    localparam int          PC_PK  = 2;
    localparam int          PC_FLT = 3;
    localparam int          PC_W   = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Register map and fields
    localparam logic [7:0]  REG_CTRL = 8'h00;
    localparam logic [7:0]  REG_STAT = 8'h04;
    localparam logic [7:0]  REG_CMD  = 8'h08;
    localparam logic [7:0]  REG_RCNT = 8'h0C;
    localparam logic [7:0]  REG_MS   = 8'h10;
    localparam logic [7:0]  REG_DAY  = 8'h14;
    localparam logic [7:0]  REG_SEL  = 8'h18;
    localparam logic [7:0]  REG_LINF = 8'h1C;
    localparam logic [7:0]  REG_LMS  = 8'h20;
    localparam logic [7:0]  REG_LDAY = 8'h24;
    localparam logic [7:0]  REG_PEAK = 8'h28;
    localparam logic [7:0]  REG_IST  = 8'h2C;
    localparam logic [7:0]  REG_ICLR = 8'h30;
    localparam logic [7:0]  REG_IEN  = 8'h34;
    localparam int          CTRL_LOGDIS = 0;
    localparam int          CTRL_POL    = 1;         // Two bits
    localparam int          CTRL_BO     = 3;
    localparam int          CMD_CLRLOG  = 0;
    localparam int          CMD_CLRCNT  = 1;
    localparam int          ST_BUSY     = 8;
    localparam int          ST_BO       = 9;
    localparam int          ST_FULL     = 10;
    localparam int          EV_LOG  = 0;
    localparam int          EV_DROP = 1;
    localparam int          EV_PEAK = 2;
    localparam int          EV_BO   = 3;
    localparam int          EV_W    = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        FPLK_POL_NONCIRC = 2'h0,
        FPLK_POL_FULL    = 2'h1,
        FPLK_POL_HALF    = 2'h2
    } fplk_pol_e;

    typedef enum logic {
        FPLK_CM_IDLE = 1'b0,
        FPLK_CM_WALK = 1'b1
    } fplk_cm_e;

    typedef struct packed {
        logic [RAIL_W-1:0] rail;
        logic [TYPE_W-1:0] ftype;
        logic [VOLT_W-1:0] volt;
        logic [31:0]       ms;
        logic [31:0]       day;
    } fplk_ent_s;

    localparam int ENT_W = $bits(fplk_ent_s);

    typedef struct packed {
        logic [2:0]                        bo_sync;
        logic                              bo_lvl;
        logic                              init;
        logic                              logdis;
        fplk_pol_e                         pol;
        logic                              bo_en;
        logic                              flush;
        logic [31:0]                       cnt;
        logic [31:0]                       ms;
        logic [31:0]                       day;
        logic [31:0]                       mscnt;
        logic                              win_on;
        logic [31:0]                       wincnt;
        logic [PC_W-1:0]                   pend;
        logic [PC_W-1:0]                   act;
        fplk_cm_e                          cm;
        logic [NV_W-1:0]                   widx;
        logic [CNT_W-1:0]                  fcnt;
        fplk_ent_s [LOG_DEPTH-1:0]         log;
        logic [RAILS-1:0][VOLT_W-1:0]      last;
        logic [RAILS-1:0][VOLT_W-1:0]      pk;
        logic [RAILS-1:0][VOLT_W-1:0]      nvpk;
        logic [7:0]                        sel;
        logic [EV_W-1:0]                   ists;
        logic [EV_W-1:0]                   ien;
        logic [31:0]                       rd_data;
        logic                              irq;
        logic                              nv_wr;
        logic [NV_W-1:0]                   nv_idx;
        logic [ENT_W-1:0]                  nv_data;
    } fplk_state_s;
endpackage
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the log keeper
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, mv = 0, fv = 0, low = 0, irq_o;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, d, rdata_o;
    logic [3:0]  ty = 4'h0, rail = 4'h3;
    logic [11:0] volt = 12'h000;
    logic        nv_wr, ce = 1, bom = 0;
    logic [5:0]  nv_idx;
    logic [83:0] nv_data;
    int          fails = 0, checks_done = 0, cyc = 0, n, m, f;
    int          ks[3] = '{0, 9, 17};
    always #50 clk_i = ~clk_i;
    fplk_keeper #(.MS_CYCLES(4), .PEAK_CYCLES(50)) uut (.clk_i, .nrst_i, .ce_i(ce),
        .rst_cnt_nv_i(32'h7), .rtc_ms_nv_i(32'h55), .rtc_day_nv_i(32'h5), .bo_mode_nv_i(bom),
        .meas_vld_i(mv), .meas_rail_i(rail), .meas_volt_i(volt), .flt_vld_i(fv),
        .flt_rail_i(rail), .flt_type_i(ty), .supply_low_i(low), .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .nv_wr_o(nv_wr), .nv_idx_o(nv_idx), .nv_data_o(nv_data), .irq_o);
    fplk_flash_model flash (.clk_i, .nv_wr_i(nv_wr), .nv_idx_i(nv_idx), .nv_data_i(nv_data),
        .wr_cnt_o(n));
    ////////////////////////////////////////
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Data taken mid-cycle while it stands
    task automatic rd(logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask
    task automatic pulse(logic [3:0] r, logic [11:0] v, logic f, int k);
        for (int i = 0; i < k; i++) begin
            @(posedge clk_i);
            rail <= r;
            volt <= v;
            ty <= i[3:0];
            mv <= !f;
            fv <= f;
        end
        @(posedge clk_i);
        mv <= 1'b0;
        fv <= 1'b0;
    endtask
    task automatic irq_is(logic e);
        repeat (2) @(negedge clk_i);
        chk("irq", {31'h0, e}, {31'h0, irq_o});
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            finish_test();
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (60) @(posedge clk_i);
        rd(8'h0C);
        chk("reset count", 32'h8, d);
        chk("flash count", 32'h8, flash.mem[0][31:0]);
        rd(8'h14);
        chk("day", 32'h0, d);
        wr(8'h10, 32'h100);
        rd(8'h10);
        chk("ms write", 32'h100, d);
        rd(8'h40);
        chk("unmapped", 32'h0, d);
        pulse(4'h5, 12'h321, 1'b0, 1);
        pulse(4'h3, 12'hABC, 1'b0, 1);
        repeat (120) @(posedge clk_i);
        chk("peak", 32'h321, flash.mem[8][31:0]);
        wr(8'h34, 32'h3);
        $display("Peak test done");
        for (int p = 0; p < 3; p++) begin
            wr(8'h00, p << 1);
            wr(8'h08, 32'h1);
            rd(8'h04);
            chk("cleared", 32'h0, d[4:0]);
            pulse(4'h3, 12'hABC, 1'b1, 20);
            rd(8'h04);
            chk("full", 32'h12, d[4:0]);
            foreach (ks[j]) begin
                f = (p == 0 || (p == 2 && ks[j] < 9)) ? ks[j] : ks[j] + 2;
                wr(8'h18, ks[j]);
                rd(8'h1C);
                chk("entry", {8'h03, 4'h0, f[3:0], 4'h0, 12'hABC}, d);
            end
            $display("Policy %0d test done", p);
        end
        rd(8'h20);
        chk("stamp", 32'h1, {31'h0, d >= 32'h100});
        wr(8'h34, 32'h0);
        irq_is(1'b0);
        wr(8'h34, 32'h3);
        irq_is(1'b1);
        wr(8'h30, 32'hF);
        irq_is(1'b0);
        wr(8'h00, 32'h1);
        pulse(4'h3, 12'hABC, 1'b1, 2);
        m = n;
        repeat (60) @(posedge clk_i);
        chk("no flash", m, n);
        ce <= 1'b0;
        wr(8'h18, 32'h0);
        ce <= 1'b1;
        rd(8'h18);
        chk("frozen", 32'h11, d);
        wr(8'h00, 32'h8);
        m = n;
        pulse(4'h3, 12'hABC, 1'b1, 2);
        repeat (60) @(posedge clk_i);
        chk("deferred", m, n);
        low <= 1'b1;
        repeat (60) @(posedge clk_i);
        chk("flushed", 32'h1, {31'h0, n > m});
        chk("clock kept", 32'h1, {31'h0, flash.mem[1][31:0] >= 32'h100});
        rd(8'h04);
        chk("supply low", 32'h1, {31'h0, d[9]});
        @(posedge clk_i);
        bom <= 1'b1;
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rd(8'h14);
        chk("day kept", 32'h5, d);
        $display("Brownout test done");
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
